// >>> hw/lcdcd_params.svh
// Offsets, field positions, reset values and opcode patterns of the command decoder
`ifndef LCDCD_PARAMS_SVH
`define LCDCD_PARAMS_SVH

// Register byte offsets
`define LCDCD_OFF_CTRL      8'h00
`define LCDCD_OFF_COLADDR   8'h04
`define LCDCD_OFF_DISPSET   8'h08
`define LCDCD_OFF_APC0      8'h0C
`define LCDCD_OFF_APC1      8'h10
`define LCDCD_OFF_FIFODATA  8'h14
`define LCDCD_OFF_STATUS    8'h18
`define LCDCD_OFF_HOSTRD    8'h1C

// Field positions
`define LCDCD_CTRL_EN_BIT        0
`define LCDCD_DISP_PARTIAL_BIT   0
`define LCDCD_DISP_RAC_LSB       4
`define LCDCD_FIFO_VALID_BIT     16
`define LCDCD_STAT_NEMPTY_BIT    0
`define LCDCD_STAT_OVF_BIT       1
`define LCDCD_STAT_FULL_BIT      2
`define LCDCD_STAT_APC_BIT       3

// Reset values
`define LCDCD_RST_COLADDR   7'h00
`define LCDCD_RST_PARTIAL   1'h0
`define LCDCD_RST_RAC       3'h1
`define LCDCD_RST_APC       8'h00
`define LCDCD_RST_HOSTRD    16'h0000
`define LCDCD_RST_EN        1'h1

// Control byte patterns
`define LCDCD_OP_CA_LSB     4'h0
`define LCDCD_OP_CA_MSB     5'h02
`define LCDCD_OP_PARTIAL    7'h42
`define LCDCD_OP_RAC        5'h11
`define LCDCD_OP_APC        7'h18

`endif

// >>> hw/lcdcd_pkg.sv
// Types shared by the command decoder modules
package lcdcd_pkg;

    typedef struct packed {
        logic        cd;
        logic [15:0] data;
    } lcdcd_bus_s;

    typedef enum logic {
        APC_IDLE  = 1'b0,
        APC_VALUE = 1'b1
    } lcdcd_apc_e;

endpackage : lcdcd_pkg

// >>> hw/lcdcd_fifo.sv
// Parameterised FIFO for display data words
`timescale 1ns/100ps
`default_nettype none

module lcdcd_fifo #(
    parameter int W     = 16,
    parameter int DEPTH = 8
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0]           wptr;
        logic [PW-1:0]           rptr;
        logic [CW-1:0]           count;
    } lcdcd_fifo_s;

    lcdcd_fifo_s st_q, st_d;
    logic        push, pop;

    assign in_ready  = (st_q.count != CW'(DEPTH));
    assign out_valid = (st_q.count != '0);
    assign out_data  = st_q.mem[st_q.rptr];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_comb begin
        st_d = st_q;
        if (push) begin
            st_d.mem[st_q.wptr] = in_data;
            st_d.wptr = (st_q.wptr == PW'(DEPTH - 1)) ? '0 : st_q.wptr + PW'(1);
        end
        if (pop) begin
            st_d.rptr = (st_q.rptr == PW'(DEPTH - 1)) ? '0 : st_q.rptr + PW'(1);
        end
        if (push && !pop) begin
            st_d.count = st_q.count + CW'(1);
        end else if (pop && !push) begin
            st_d.count = st_q.count - CW'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

endmodule : lcdcd_fifo
`default_nettype wire

// >>> hw/lcdcd_strobe_capture.sv
// Samples the parallel bus and flags the rising edge of the write strobe
`timescale 1ns/100ps
`default_nettype none

module lcdcd_strobe_capture (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               chip_select_n,
    input  wire logic               cd_sel,
    input  wire logic               write_strobe_n,
    input  wire logic [15:0]        parallel_data_bus,
    output logic                    cap_valid,
    output lcdcd_pkg::lcdcd_bus_s   cap_bus
);
    typedef struct packed {
        logic                  wr_prev_n;
        logic                  cs_prev_n;
        lcdcd_pkg::lcdcd_bus_s held;
    } lcdcd_cap_s;

    lcdcd_cap_s st_q, st_d;

    // Zero hold time on the bus: use the values seen while the strobe was low
    assign cap_valid = !st_q.wr_prev_n && write_strobe_n && !st_q.cs_prev_n;
    assign cap_bus   = st_q.held;

    always_comb begin
        st_d           = st_q;
        st_d.wr_prev_n = write_strobe_n;
        st_d.cs_prev_n = chip_select_n;
        if (!write_strobe_n) begin
            st_d.held.cd   = cd_sel;
            st_d.held.data = parallel_data_bus;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '{wr_prev_n: 1'b1, cs_prev_n: 1'b1, held: '0};
        end else begin
            st_q <= st_d;
        end
    end

endmodule : lcdcd_strobe_capture
`default_nettype wire

// >>> hw/lcdcd_decoder.sv
// Host command and data decoder of the display controller, with APB registers
// Function
// - Select line low means control byte, high means display data.
// - Direction zero is a host write; one lets the device drive the bus. The code has no direction line; it drives the bus while selected,
//   read_strobe_n is low and write_strobe_n is high.
// - Control byte 0000xxxx loads column address low nibble; resets to zero.
// - Control byte 00010xxx loads column address upper three bits; resets to zero.
// - Control byte 1000010x sets partial display enable; default zero.
// - Control byte 10001xxx loads RAM address control field; resets to 001b.
// - Byte 0011000R then a full value byte writes program register R.
// - Control bytes use only the low eight data bits.
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "lcdcd_params.svh"

module lcdcd_decoder #(
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        chip_select_n,
    input  wire logic        cd_sel,
    input  wire logic        write_strobe_n,
    input  wire logic        read_strobe_n,
    input  wire logic [15:0] parallel_data_in,
    output logic [15:0]      parallel_data_out,
    output logic             parallel_data_oe,
    output logic             host_busy
);

    ////////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic                   enable;
        logic [6:0]             column_address;
        logic                   partial_enable;
        logic [2:0]             ram_address_control_field;
        logic [7:0]             apc0;
        logic [7:0]             apc1;
        lcdcd_pkg::lcdcd_apc_e  apc_phase;
        logic                   apc_sel;
        logic                   overflow;
        logic [15:0]            host_rdata;
        logic [31:0]            prdata;
        logic                   pready;
        logic                   pslverr;
        logic [15:0]            data_out;
        logic                   data_oe;
        logic                   busy;
    } lcdcd_top_s;

    lcdcd_top_s                 st_q, st_d;
    logic                       cap_valid;
    lcdcd_pkg::lcdcd_bus_s      cap_bus;
    logic                       fifo_in_valid;
    logic                       fifo_in_ready;
    logic                       fifo_out_valid;
    logic                       fifo_out_ready;
    logic [15:0]                fifo_out_data;
    logic [7:0]                 cmd;
    logic                       cmd_valid;
    logic                       apb_setup_done;
    logic                       apb_finish;
    logic                       apb_wr;
    logic                       apb_rd;

    ////////////////////////////////////////////////////////////////////////////////
    // Parallel bus capture and data path

    lcdcd_strobe_capture u_cap (
        .pclk              (pclk),
        .presetn           (presetn),
        .chip_select_n     (chip_select_n),
        .cd_sel            (cd_sel),
        .write_strobe_n    (write_strobe_n),
        .parallel_data_bus (parallel_data_in),
        .cap_valid         (cap_valid),
        .cap_bus           (cap_bus)
    );

    // Display data words go to the FIFO; full words are dropped and flagged
    assign fifo_in_valid = cap_valid && st_q.enable && cap_bus.cd;
    assign cmd_valid     = cap_valid && st_q.enable && !cap_bus.cd;
    // Upper byte ignored for control bytes
    assign cmd           = cap_bus.data[7:0];

    lcdcd_fifo #(
        .W     (16),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (cap_bus.data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // APB handshake: one wait state, answer with pready on the second access cycle

    assign apb_setup_done = psel && penable && !st_q.pready;
    assign apb_finish     = psel && penable && st_q.pready;
    assign apb_wr         = apb_finish && pwrite;
    assign apb_rd         = apb_finish && !pwrite;
    // Pop only when the read that carried the head word completes
    assign fifo_out_ready = apb_rd && (paddr == `LCDCD_OFF_FIFODATA);

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        st_d         = st_q;
        st_d.pready  = apb_setup_done;
        st_d.busy    = !fifo_in_ready;

        // Device drives the bus only during a selected read cycle
        st_d.data_oe  = !chip_select_n && !read_strobe_n && write_strobe_n;
        st_d.data_out = st_q.host_rdata;

        // Command decoding; a pending program value byte takes precedence
        if (cmd_valid) begin
            if (st_q.apc_phase == lcdcd_pkg::APC_VALUE) begin
                if (st_q.apc_sel) begin
                    st_d.apc1 = cmd;
                end else begin
                    st_d.apc0 = cmd;
                end
                st_d.apc_phase = lcdcd_pkg::APC_IDLE;
            end else if (cmd[7:4] == `LCDCD_OP_CA_LSB) begin
                st_d.column_address[3:0] = cmd[3:0];
            end else if (cmd[7:3] == `LCDCD_OP_CA_MSB) begin
                st_d.column_address[6:4] = cmd[2:0];
            end else if (cmd[7:1] == `LCDCD_OP_PARTIAL) begin
                st_d.partial_enable = cmd[0];
            end else if (cmd[7:3] == `LCDCD_OP_RAC) begin
                st_d.ram_address_control_field = cmd[2:0];
            end else if (cmd[7:1] == `LCDCD_OP_APC) begin
                st_d.apc_phase = lcdcd_pkg::APC_VALUE;
                st_d.apc_sel   = cmd[0];
            end
            // Other encodings are left without effect
        end

        // Register read data, prepared one cycle before pready rises
        if (apb_setup_done) begin
            st_d.prdata  = 32'h0000_0000;
            st_d.pslverr = 1'b0;
            if (paddr == `LCDCD_OFF_CTRL) begin
                st_d.prdata[`LCDCD_CTRL_EN_BIT] = st_q.enable;
            end else if (paddr == `LCDCD_OFF_COLADDR) begin
                st_d.prdata[6:0] = st_q.column_address;
            end else if (paddr == `LCDCD_OFF_DISPSET) begin
                st_d.prdata[`LCDCD_DISP_PARTIAL_BIT] = st_q.partial_enable;
                st_d.prdata[`LCDCD_DISP_RAC_LSB +: 3] = st_q.ram_address_control_field;
            end else if (paddr == `LCDCD_OFF_APC0) begin
                st_d.prdata[7:0] = st_q.apc0;
            end else if (paddr == `LCDCD_OFF_APC1) begin
                st_d.prdata[7:0] = st_q.apc1;
            end else if (paddr == `LCDCD_OFF_FIFODATA) begin
                st_d.prdata[15:0] = fifo_out_valid ? fifo_out_data : 16'h0000;
                st_d.prdata[`LCDCD_FIFO_VALID_BIT] = fifo_out_valid;
            end else if (paddr == `LCDCD_OFF_STATUS) begin
                st_d.prdata[`LCDCD_STAT_NEMPTY_BIT] = fifo_out_valid;
                st_d.prdata[`LCDCD_STAT_OVF_BIT]    = st_q.overflow;
                st_d.prdata[`LCDCD_STAT_FULL_BIT]   = !fifo_in_ready;
                st_d.prdata[`LCDCD_STAT_APC_BIT]    = (st_q.apc_phase == lcdcd_pkg::APC_VALUE);
            end else if (paddr == `LCDCD_OFF_HOSTRD) begin
                st_d.prdata[15:0] = st_q.host_rdata;
            end else begin
                st_d.pslverr = 1'b1;
            end
        end else begin
            // Error stands only beside pready, never into the next cycle
            st_d.pslverr = 1'b0;
        end

        // Register writes take effect at the completing edge
        if (apb_wr) begin
            if (paddr == `LCDCD_OFF_CTRL) begin
                st_d.enable = pwdata[`LCDCD_CTRL_EN_BIT];
            end else if (paddr == `LCDCD_OFF_STATUS) begin
                if (pwdata[`LCDCD_STAT_OVF_BIT]) begin
                    st_d.overflow = 1'b0;
                end
            end else if (paddr == `LCDCD_OFF_HOSTRD) begin
                st_d.host_rdata = pwdata[15:0];
            end
        end

        // Set after the clear so a drop in the clearing cycle is kept
        if (fifo_in_valid && !fifo_in_ready) begin
            st_d.overflow = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '{
                enable:                    `LCDCD_RST_EN,
                column_address:            `LCDCD_RST_COLADDR,
                partial_enable:            `LCDCD_RST_PARTIAL,
                ram_address_control_field: `LCDCD_RST_RAC,
                apc0:                      `LCDCD_RST_APC,
                apc1:                      `LCDCD_RST_APC,
                apc_phase:                 lcdcd_pkg::APC_IDLE,
                apc_sel:                   1'b0,
                overflow:                  1'b0,
                host_rdata:                `LCDCD_RST_HOSTRD,
                prdata:                    32'h0000_0000,
                pready:                    1'b0,
                pslverr:                   1'b0,
                data_out:                  16'h0000,
                data_oe:                   1'b0,
                busy:                      1'b0
            };
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign prdata            = st_q.prdata;
    assign pready            = st_q.pready;
    assign pslverr           = st_q.pslverr;
    assign parallel_data_out = st_q.data_out;
    assign parallel_data_oe  = st_q.data_oe;
    // Busy tells the host to hold off data writes while the FIFO is full
    assign host_busy         = st_q.busy;

endmodule : lcdcd_decoder
`default_nettype wire

// >>> testbench/lcdcd_assertions.sv
// Port-level assertions of the command decoder
`timescale 1ns/100ps
`default_nettype none

module lcdcd_assertions (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        chip_select_n,
    input wire logic        cd_sel,
    input wire logic        write_strobe_n,
    input wire logic        read_strobe_n,
    input wire logic [15:0] parallel_data_in,
    input wire logic [15:0] parallel_data_out,
    input wire logic        parallel_data_oe,
    input wire logic        host_busy
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////
    access_to_ready_a: assert property (psel && penable && !pready |=> pready)
        else $error("pready missing after access");
    ready_one_cycle_a: assert property (pready |=> !pready)
        else $error("pready held too long");
    ready_needs_access_a: assert property (pready |-> $past(psel && penable))
        else $error("pready without access");
    error_with_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr outside answer");
    error_zero_data_a: assert property (pslverr |-> prdata == 32'h0)
        else $error("prdata not zero on error");
    read_drive_a: assert property (
        !chip_select_n && !read_strobe_n && write_strobe_n |=> parallel_data_oe)
        else $error("bus not driven on read");
    strobe_release_a: assert property (read_strobe_n |=> !parallel_data_oe)
        else $error("bus driven after read");
    deselect_release_a: assert property (chip_select_n |=> !parallel_data_oe)
        else $error("bus driven while deselected");
    ////////////////////////////////////////
    cover property (pslverr);
    cover property ($rose(parallel_data_oe));
    cover property ($rose(host_busy));
endmodule : lcdcd_assertions

`default_nettype wire

// >>> testbench/lcdcd_host_model.sv
// Host microcontroller model on the parallel strobe bus
`timescale 1ns/100ps
`default_nettype none

module lcdcd_host_model (
    input  wire logic        pclk,
    output logic             chip_select_n,
    output logic             cd_sel,
    output logic             write_strobe_n,
    output logic             read_strobe_n,
    output logic [15:0]      parallel_data_in,
    input  wire logic [15:0] parallel_data_out,
    input  wire logic        parallel_data_oe
);
    logic [15:0] dq;
    logic        drv;

    // Released bus shows parallel_data_out while parallel_data_oe is high, else the inverse of the last value, never a held copy
    assign parallel_data_in = drv ? dq : (parallel_data_oe ? parallel_data_out : ~dq);

    initial begin
        chip_select_n  = 1'b1;
        cd_sel         = 1'b0;
        write_strobe_n = 1'b1;
        read_strobe_n  = 1'b1;
        dq             = 16'h0000;
        drv            = 1'b0;
    end
    ////////////////////////////////////////
    task wr(input logic cs_n, input logic cd, input logic [15:0] d);
        @(posedge pclk);
        chip_select_n  <= cs_n;
        cd_sel         <= cd;
        dq             <= d;
        drv            <= 1'b1;
        write_strobe_n <= 1'b0;
        @(posedge pclk);
        write_strobe_n <= 1'b1;
        @(posedge pclk);
        chip_select_n  <= 1'b1;
        drv            <= 1'b0;
    endtask : wr

    task rd(output logic [15:0] q);
        @(posedge pclk);
        chip_select_n <= 1'b0;
        cd_sel        <= 1'b1;
        read_strobe_n <= 1'b0;
        repeat (2) @(posedge pclk);
        q = parallel_data_in;
        read_strobe_n <= 1'b1;
        chip_select_n <= 1'b1;
    endtask : rd
endmodule : lcdcd_host_model

`default_nettype wire

// >>> testbench/test_lcd_host_command_decoder.sv
// Self-checking bench of the command decoder
`timescale 1ns/100ps
`default_nettype none

module test_lcd_host_command_decoder;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic        cs_n, cd, wr_n, rd_n, oe, busy;
    logic [15:0] din, dout, h;
    int          n_mismatch, n_tests, i;
    logic [7:0]  offs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18, 8'h1C};
    logic [31:0] rst  [7] = '{32'h1, 32'h0, 32'h10, 32'h0, 32'h0, 32'h0, 32'h0};

    lcdcd_decoder #(.FIFO_DEPTH(8)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .chip_select_n(cs_n),
        .cd_sel(cd), .write_strobe_n(wr_n), .read_strobe_n(rd_n),
        .parallel_data_in(din), .parallel_data_out(dout), .parallel_data_oe(oe),
        .host_busy(busy));
    lcdcd_host_model host (.pclk(pclk), .chip_select_n(cs_n), .cd_sel(cd),
        .write_strobe_n(wr_n), .read_strobe_n(rd_n), .parallel_data_in(din),
        .parallel_data_out(dout), .parallel_data_oe(oe));
    ////////////////////////////////////////
    task chk(input string s, input logic [31:0] x, input logic [31:0] y);
        n_tests++;
        if (y !== x) begin
            n_mismatch++;
            $display("[ERR] %s exp %h got %h", s, x, y);
        end
    endtask : chk

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task results;
        $display("Counts: %0d checks, %0d mismatches", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : results
    ////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Whole run needs about 210 cycles; 20000 leaves wide margin
    initial begin
        #200000;
        n_mismatch++;
        results();
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        n_mismatch = 0;
        n_tests    = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (16) @(posedge pclk);
        for (i = 0; i < 7; i++) begin
            apb(1'b0, offs[i], 32'h0);
            chk("reset value", rst[i], q);
        end
        $display("Test reset values done");
        host.wr(1'b0, 1'b0, 16'hFF05);
        host.wr(1'b0, 1'b0, 16'h0013);
        apb(1'b0, 8'h04, 32'h0);
        chk("column address", 32'h35, q);
        host.wr(1'b0, 1'b0, 16'h0085);
        host.wr(1'b0, 1'b0, 16'h008E);
        apb(1'b0, 8'h08, 32'h0);
        chk("display settings", 32'h61, q);
        host.wr(1'b0, 1'b0, 16'h0030);
        host.wr(1'b0, 1'b0, 16'h00A5);
        host.wr(1'b0, 1'b0, 16'h0031);
        host.wr(1'b0, 1'b0, 16'h0007);
        apb(1'b0, 8'h0C, 32'h0);
        chk("program reg 0", 32'hA5, q);
        apb(1'b0, 8'h10, 32'h0);
        chk("program reg 1", 32'h07, q);
        $display("Test commands done");
        // Strobes ignored while disabled or deselected
        apb(1'b1, 8'h00, 32'h0);
        host.wr(1'b0, 1'b0, 16'h000F);
        apb(1'b1, 8'h00, 32'h1);
        host.wr(1'b1, 1'b0, 16'h000A);
        apb(1'b0, 8'h04, 32'h0);
        chk("column address", 32'h35, q);
        $display("Test ignored strobes done");
        for (i = 0; i < 9; i++) host.wr(1'b0, 1'b1, 16'(i));
        chk("busy", 32'h1, {31'h0, busy});
        apb(1'b0, 8'h18, 32'h0);
        chk("status full", 32'h7, q);
        for (i = 0; i < 8; i++) begin
            apb(1'b0, 8'h14, 32'h0);
            chk("fifo word", 32'h10000 | i, q);
        end
        apb(1'b0, 8'h18, 32'h0);
        chk("status drained", 32'h2, q);
        apb(1'b1, 8'h18, 32'h2);
        apb(1'b0, 8'h18, 32'h0);
        chk("status cleared", 32'h0, q);
        chk("busy", 32'h0, {31'h0, busy});
        apb(1'b0, 8'h04, 32'h0);
        chk("column address", 32'h35, q);
        $display("Test data path done");
        apb(1'b1, 8'h1C, 32'hBEEF);
        host.rd(h);
        chk("host read", 32'hBEEF, {16'h0, h});
        $display("Test host read done");
        apb(1'b0, 8'h20, 32'h0);
        chk("slave error", 32'h1, {31'h0, e});
        chk("error data", 32'h0, q);
        $display("Test unmapped done");
        results();
    end
endmodule : test_lcd_host_command_decoder

bind lcdcd_decoder lcdcd_assertions chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chip_select_n(chip_select_n), .cd_sel(cd_sel), .write_strobe_n(write_strobe_n),
    .read_strobe_n(read_strobe_n), .parallel_data_in(parallel_data_in),
    .parallel_data_out(parallel_data_out), .parallel_data_oe(parallel_data_oe),
    .host_busy(host_busy));

`default_nettype wire
